// File: hw/rps_pkg.sv
package rps_pkg;

	////////////////////////////////////////////////////////////////////////
	// comparator event inputs
	typedef struct packed {
		logic sync_low;
		logic ramp_on;
		logic ramp_ctl;
		logic ramp_top;
		logic vs_en;
		logic vs_low;
		logic vs_brown;
		logic otemp;
	} rps_cmp_t;

	localparam int CMP_W  = $bits(rps_cmp_t);
	localparam int PROG_W = 2;

	// ramp capacitor drive
	typedef struct packed {
		logic fast;
		logic charge;
		logic discharge;
	} rps_ramp_t;

	////////////////////////////////////////////////////////////////////////
	// operating modes from the programming pin
	typedef enum logic [1:0] {
		MODE_REV_TWO_STAGE = 2'h0,
		MODE_STATIC_ZV     = 2'h1,
		MODE_REV_SWITCHOFF = 2'h2
	} rps_mode_t;

	// ramp sequencer states
	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_FAST1 = 5'h02,
		ST_ON    = 5'h04,
		ST_FAST2 = 5'h08,
		ST_DISCH = 5'h10
	} rps_state_t;

	////////////////////////////////////////////////////////////////////////
	// register map
	localparam int          ADDR_W      = 4;
	localparam int          DATA_W      = 16;
	localparam logic [3:0]  ADDR_CTRL   = 4'h0;
	localparam logic [3:0]  ADDR_STATUS = 4'h4;
	localparam logic [3:0]  ADDR_MASK   = 4'h8;
	localparam logic [3:0]  ADDR_STATE  = 4'hc;

	localparam int          CTRL_W      = 2;
	localparam int          CTRL_EN     = 0;
	localparam int          CTRL_AC     = 1;
	localparam logic [1:0]  CTRL_RST    = 2'h0;

	localparam int          EV_W        = 6;
	localparam int          EV_ZC       = 0;
	localparam int          EV_GATE_ON  = 1;
	localparam int          EV_GATE_OFF = 2;
	localparam int          EV_BROWN    = 3;
	localparam int          EV_OTEMP    = 4;
	localparam int          EV_SUPPLY   = 5;
	localparam logic [5:0]  EV_RST      = 6'h00;

endpackage

// File: hw/rps_sync.sv
`timescale 1ns/10ps
module rps_sync #(
	parameter int W = 8
) (
	input  wire logic         i_mclk,
	input  wire logic         i_srst,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_lvl,
	output logic      [W-1:0] o_rise,
	output logic      [W-1:0] o_fall
);

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	////////////////////////////////////////////////////////////////////////
	// two-flop synchroniser and edge detector per bit
	genvar g;
	for (g = 0; g < W; g++) begin : g_bit
		always_ff @(posedge i_mclk) begin
			if (i_srst) begin
				s1_q[g] <= 1'b0;
				s2_q[g] <= 1'b0;
				s3_q[g] <= 1'b0;
			end else begin
				s1_q[g] <= i_async[g];
				s2_q[g] <= s1_q[g];
				s3_q[g] <= s2_q[g];
			end
		end
		assign o_lvl[g]  = s2_q[g];
		assign o_rise[g] = s2_q[g] & ~s3_q[g];
		assign o_fall[g] = ~s2_q[g] & s3_q[g];
	end

endmodule

// File: hw/rps_zc_div.sv
`timescale 1ns/10ps
module rps_zc_div (
	input  wire logic i_mclk,
	input  wire logic i_rst,
	input  wire logic i_zc,
	input  wire logic i_halve,
	output logic      o_zc
);

	logic phase_q;

	// passes every crossing, or every second one when halving
	always_ff @(posedge i_mclk) begin
		if (i_rst)
			phase_q <= 1'b0;
		else if (i_zc)
			phase_q <= ~phase_q;
	end

	assign o_zc = i_zc & (~i_halve | phase_q);

endmodule

// File: hw/rps_seq.sv
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
module rps_seq (
	input  wire logic                          i_mclk,
	input  wire logic                          i_srst,
	input  wire rps_pkg::rps_cmp_t             i_cmp,
	input  wire logic [rps_pkg::PROG_W-1:0]    i_prog,
	input  wire logic [rps_pkg::ADDR_W-1:0]    i_addr,
	input  wire logic [rps_pkg::DATA_W-1:0]    i_wdata,
	input  wire logic                          i_wr,
	input  wire logic                          i_rd,
	output logic      [rps_pkg::DATA_W-1:0]    o_rdata,
	output logic                               o_irq,
	output logic                               o_gate_drive_output,
	output rps_pkg::rps_ramp_t                 o_ramp
);

	localparam int SW = rps_pkg::CMP_W + rps_pkg::PROG_W;

	logic [SW-1:0]                  s_lvl;
	logic [SW-1:0]                  s_rise;
	rps_pkg::rps_cmp_t              lvl;
	rps_pkg::rps_cmp_t              rise;
	rps_pkg::rps_mode_t             mode_q;
	rps_pkg::rps_state_t            state_q;
	rps_pkg::rps_state_t            state_d;
	logic                           supply_ok_q;
	logic                           logic_rst;
	logic                           zc_evt;
	logic                           otemp_q;
	logic                           brown_q;
	logic                           first_q;
	logic                           zv_seen_q;
	logic                           permit;
	logic                           gate_d;
	logic [rps_pkg::CTRL_W-1:0]     ctrl_q;
	logic [rps_pkg::EV_W-1:0]       status_q;
	logic [rps_pkg::EV_W-1:0]       mask_q;
	logic [rps_pkg::EV_W-1:0]       ev;

	function automatic logic is_reverse(input rps_pkg::rps_mode_t m);
		return m != rps_pkg::MODE_STATIC_ZV;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// input synchronisation
	rps_sync #(
		.W (SW)
	) u_sync (
		.i_mclk  (i_mclk),
		.i_srst  (i_srst),
		.i_async ({i_prog, i_cmp}),
		.o_lvl   (s_lvl),
		.o_rise  (s_rise),
		.o_fall  ()
	);

	assign lvl  = rps_pkg::rps_cmp_t'(s_lvl[rps_pkg::CMP_W-1:0]);
	assign rise = rps_pkg::rps_cmp_t'(s_rise[rps_pkg::CMP_W-1:0]);

	// the programming pin sets the mode while logic is held
	always_ff @(posedge i_mclk) begin
		if (i_srst)
			mode_q <= rps_pkg::MODE_REV_TWO_STAGE;
		else if (logic_rst)
			mode_q <= rps_pkg::rps_mode_t'(s_lvl[SW-1 -: rps_pkg::PROG_W]);
	end

	////////////////////////////////////////////////////////////////////////
	// supply monitor
	always_ff @(posedge i_mclk) begin
		if (i_srst)
			supply_ok_q <= 1'b0;
		else if (lvl.vs_low)
			supply_ok_q <= 1'b0;
		else if (lvl.vs_en)
			supply_ok_q <= 1'b1;
	end

	assign logic_rst = i_srst | ~supply_ok_q;

	rps_zc_div u_div (
		.i_mclk  (i_mclk),
		.i_rst   (logic_rst),
		.i_zc    (rise.sync_low),
		.i_halve (ctrl_q[rps_pkg::CTRL_AC]),
		.o_zc    (zc_evt)
	);

	////////////////////////////////////////////////////////////////////////
	// protection latches
	always_ff @(posedge i_mclk) begin
		if (i_srst)
			otemp_q <= 1'b0;
		else if (lvl.otemp)
			otemp_q <= 1'b1;
		else if (~supply_ok_q)
			otemp_q <= 1'b0;
	end

	always_ff @(posedge i_mclk) begin
		if (logic_rst)
			brown_q <= 1'b0;
		else if (lvl.vs_brown && is_reverse(mode_q))
			brown_q <= 1'b1;
		else if (zc_evt)
			brown_q <= 1'b0;
	end

	// single power-up cycle, independent of software enable
	always_ff @(posedge i_mclk) begin
		if (logic_rst) begin
			first_q   <= 1'b1;
			zv_seen_q <= 1'b0;
		end else if (is_reverse(mode_q)) begin
			if (state_q == rps_pkg::ST_FAST2 && state_d == rps_pkg::ST_DISCH)
				first_q <= 1'b0;
		end else if (zc_evt) begin
			zv_seen_q <= 1'b1;
			if (zv_seen_q)
				first_q <= 1'b0;
		end
	end

	assign permit = (ctrl_q[rps_pkg::CTRL_EN] | first_q) & ~otemp_q & ~brown_q;

	////////////////////////////////////////////////////////////////////////
	// ramp sequencer
	always_comb begin
		state_d = state_q;
		if (!is_reverse(mode_q))
			state_d = rps_pkg::ST_IDLE;
		else if (zc_evt)
			state_d = rps_pkg::ST_FAST1;
		else begin
			unique case (state_q)
				rps_pkg::ST_IDLE: state_d = rps_pkg::ST_IDLE;
				rps_pkg::ST_FAST1: begin
					if (lvl.ramp_on)
						state_d = rps_pkg::ST_ON;
				end
				rps_pkg::ST_ON: begin
					if (lvl.ramp_ctl)
						state_d = rps_pkg::ST_FAST2;
				end
				rps_pkg::ST_FAST2: begin
					if (lvl.ramp_top)
						state_d = rps_pkg::ST_DISCH;
				end
				rps_pkg::ST_DISCH: begin
					if (!lvl.ramp_on)
						state_d = rps_pkg::ST_IDLE;
				end
				default: state_d = rps_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_mclk) begin
		if (logic_rst)
			state_q <= rps_pkg::ST_IDLE;
		else
			state_q <= state_d;
	end

	always_ff @(posedge i_mclk) begin
		if (logic_rst)
			o_ramp <= '0;
		else begin
			o_ramp.fast      <= state_d == rps_pkg::ST_FAST1 ||
			                    state_d == rps_pkg::ST_FAST2;
			o_ramp.charge    <= state_d == rps_pkg::ST_FAST1 ||
			                    state_d == rps_pkg::ST_ON ||
			                    state_d == rps_pkg::ST_FAST2;
			o_ramp.discharge <= state_d == rps_pkg::ST_DISCH;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// gate drive
	always_comb begin
		if (is_reverse(mode_q))
			gate_d = state_d == rps_pkg::ST_ON && permit;
		else if (zc_evt)
			gate_d = permit;
		else
			gate_d = o_gate_drive_output & ~otemp_q;
	end

	always_ff @(posedge i_mclk) begin
		if (logic_rst)
			o_gate_drive_output <= 1'b0;
		else
			o_gate_drive_output <= gate_d;
	end

	////////////////////////////////////////////////////////////////////////
	// register port and interrupt
	assign ev[rps_pkg::EV_ZC]       = zc_evt;
	assign ev[rps_pkg::EV_GATE_ON]  = gate_d & ~o_gate_drive_output & ~logic_rst;
	assign ev[rps_pkg::EV_GATE_OFF] = ~gate_d & o_gate_drive_output & ~logic_rst;
	assign ev[rps_pkg::EV_BROWN]    = lvl.vs_brown & ~brown_q &
	                                  is_reverse(mode_q) & ~logic_rst;
	assign ev[rps_pkg::EV_OTEMP]    = lvl.otemp & ~otemp_q;
	assign ev[rps_pkg::EV_SUPPLY]   = lvl.vs_low & supply_ok_q;

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			ctrl_q <= rps_pkg::CTRL_RST;
			mask_q <= rps_pkg::EV_RST;
		end else if (i_wr) begin
			if (i_addr == rps_pkg::ADDR_CTRL)
				ctrl_q <= i_wdata[rps_pkg::CTRL_W-1:0];
			if (i_addr == rps_pkg::ADDR_MASK)
				mask_q <= i_wdata[rps_pkg::EV_W-1:0];
		end
	end

	// write one to clear, a new event wins over the clear
	always_ff @(posedge i_mclk) begin
		if (i_srst)
			status_q <= rps_pkg::EV_RST;
		else if (i_wr && i_addr == rps_pkg::ADDR_STATUS)
			status_q <= (status_q & ~i_wdata[rps_pkg::EV_W-1:0]) | ev;
		else
			status_q <= status_q | ev;
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst)
			o_irq <= 1'b0;
		else
			o_irq <= |(status_q & mask_q);
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst || !i_rd)
			o_rdata <= '0;
		else begin
			unique case (i_addr)
				rps_pkg::ADDR_CTRL:   o_rdata <= 16'(ctrl_q);
				rps_pkg::ADDR_STATUS: o_rdata <= 16'(status_q);
				rps_pkg::ADDR_MASK:   o_rdata <= 16'(mask_q);
				rps_pkg::ADDR_STATE:  o_rdata <= {4'h0, first_q, brown_q,
				                         otemp_q, supply_ok_q, mode_q,
				                         o_gate_drive_output, state_q};
				default:              o_rdata <= '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_srst);

	sequence s_rev_live;
		is_reverse(mode_q) && supply_ok_q && !lvl.vs_low;
	endsequence

	sequence s_no_zc;
		!zc_evt;
	endsequence

	a_zc_restart: assert property (s_rev_live and zc_evt |=>
		state_q == rps_pkg::ST_FAST1 || !supply_ok_q)
		else $error("ramp did not restart on zero crossing");

	a_fast_current: assert property (state_q == rps_pkg::ST_FAST1 |->
		o_ramp.fast && o_ramp.charge)
		else $error("fast ramp current missing");

	a_low_thresh: assert property (s_rev_live and s_no_zc and
		state_q == rps_pkg::ST_FAST1 && lvl.ramp_on |=>
		state_q == rps_pkg::ST_ON && !o_ramp.fast)
		else $error("output not started at ramp threshold");

	a_ctl_thresh: assert property (s_rev_live and s_no_zc and
		state_q == rps_pkg::ST_ON && lvl.ramp_ctl |=>
		!o_gate_drive_output && o_ramp.fast)
		else $error("output not stopped at control level");

	a_top_thresh: assert property (s_rev_live and s_no_zc and
		state_q == rps_pkg::ST_FAST2 && lvl.ramp_top |=>
		o_ramp.discharge && !o_ramp.charge)
		else $error("ramp not discharged at top");

	a_logic_reset: assert property (!supply_ok_q |=>
		!o_gate_drive_output && state_q == rps_pkg::ST_IDLE)
		else $error("logic active with invalid supply");

	a_enable_wait: assert property (!supply_ok_q && !lvl.vs_en |=>
		!supply_ok_q)
		else $error("enabled below threshold");

	a_collapse: assert property (lvl.vs_low |=> !supply_ok_q)
		else $error("no reset on supply collapse");

	a_brown_cut: assert property ($rose(brown_q) |=>
		!o_gate_drive_output)
		else $error("brownout did not cut output");

	a_brown_hold: assert property (brown_q && !zc_evt &&
		supply_ok_q && !lvl.vs_low |=> brown_q)
		else $error("output released before half-wave");

	a_first_cycle: assert property ($rose(supply_ok_q) |-> first_q)
		else $error("power-up cycle not armed");

	a_otemp_off: assert property (otemp_q |=> !o_gate_drive_output)
		else $error("output on while over temperature");

	a_otemp_hold: assert property (otemp_q && supply_ok_q |=>
		otemp_q)
		else $error("over-temperature released without power cycle");

	a_gate_in_on: assert property (is_reverse(mode_q) &&
		o_gate_drive_output |-> state_q == rps_pkg::ST_ON)
		else $error("gate on outside the on phase");

	a_zc_fast: assert property (s_rev_live and zc_evt |=>
		o_ramp.fast && o_ramp.charge && !o_gate_drive_output)
		else $error("zero crossing did not select fast current");

	a_static_idle: assert property (!is_reverse(mode_q) |=>
		state_q == rps_pkg::ST_IDLE && o_ramp == '0)
		else $error("ramp active in static mode");

endmodule

// File: testbench/rps_ramp_model.sv
`timescale 1ns/10ps
module rps_ramp_model (
	input  wire logic               i_mclk,
	input  wire rps_pkg::rps_ramp_t i_ramp,
	input  wire logic [9:0]         i_ctl,
	output logic                    o_on,
	output logic                    o_ctl,
	output logic                    o_top
);
	logic [9:0] v_q = 10'h000;

	// ramp capacitor, fast current charges four times quicker
	always @(posedge i_mclk) begin
		if (i_ramp.discharge)
			v_q <= (v_q > 10'h008) ? v_q - 10'h008 : 10'h000;
		else if (i_ramp.charge && v_q < 10'h3f0)
			v_q <= v_q + (i_ramp.fast ? 10'h004 : 10'h001);
	end

	// threshold comparators
	assign o_on  = v_q >= 10'h02d;
	assign o_ctl = v_q >= i_ctl;
	assign o_top = v_q >= 10'h226;
endmodule

// File: testbench/rps_seq_tb_top.sv
`timescale 1ns/10ps
module rps_seq_tb_top;
	logic                             i_mclk   = 1'b0;
	logic                             i_srst   = 1'b1;
	logic [rps_pkg::PROG_W-1:0]       i_prog   = 2'h0;
	logic [rps_pkg::ADDR_W-1:0]       i_addr   = 4'h0;
	logic [rps_pkg::DATA_W-1:0]       i_wdata  = 16'h0000;
	logic                             i_wr     = 1'b0;
	logic                             i_rd     = 1'b0;
	logic                             sync_low = 1'b0;
	logic                             vs_en    = 1'b0;
	logic                             vs_low   = 1'b1;
	logic                             vs_brown = 1'b0;
	logic                             otemp    = 1'b0;
	logic                             probe    = 1'b0;
	logic                             rd_d     = 1'b0;
	logic [9:0]                       ctl_lvl  = 10'h0c8;
	logic                             r_on;
	logic                             r_ctl;
	logic                             r_top;
	rps_pkg::rps_cmp_t                cmp;
	logic [rps_pkg::DATA_W-1:0]       o_rdata;
	logic                             o_irq;
	logic                             o_gate_drive_output;
	rps_pkg::rps_ramp_t               o_ramp;
	logic [4:0]                       pins;
	logic [31:0]                      note;
	logic [15:0]                      got;
	logic [31:0]                      note_q[$];
	int                               n_fail      = 0;
	int                               check_count = 0;

	assign cmp  = {sync_low, r_on, r_ctl, r_top, vs_en, vs_low, vs_brown, otemp};
	assign pins = {o_irq, o_gate_drive_output, o_ramp};

	initial begin
		forever #25 i_mclk = ~i_mclk;
	end

	rps_seq rps_seq_i (
		.i_mclk              (i_mclk),
		.i_srst              (i_srst),
		.i_cmp               (cmp),
		.i_prog              (i_prog),
		.i_addr              (i_addr),
		.i_wdata             (i_wdata),
		.i_wr                (i_wr),
		.i_rd                (i_rd),
		.o_rdata             (o_rdata),
		.o_irq               (o_irq),
		.o_gate_drive_output (o_gate_drive_output),
		.o_ramp              (o_ramp)
	);

	rps_ramp_model rps_ramp_model_i (
		.i_mclk (i_mclk),
		.i_ramp (o_ramp),
		.i_ctl  (ctl_lvl),
		.o_on   (r_on),
		.o_ctl  (r_ctl),
		.o_top  (r_top)
	);

	////////////////////////////////////////////////////////////////////////
	// monitor: oldest note against read data or sampled pins
	always @(posedge i_mclk) begin
		rd_d <= i_rd;
		if (rd_d || probe) begin
			note = note_q.pop_front();
			got = rd_d ? o_rdata : {11'h000, pins};
			check_count++;
			if ((got & note[15:0]) !== note[31:16]) begin
				$display("wrong value at %0t: got %h expected %h", $time,
					got & note[15:0], note[31:16]);
				n_fail++;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	task test_done;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task step(input int n);
		repeat (n) @(posedge i_mclk);
	endtask

	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge i_mclk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask

	task rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
		@(posedge i_mclk);
		i_rd <= 1'b1;
		i_addr <= a;
		note_q.push_back({e, m});
		@(posedge i_mclk);
		i_rd <= 1'b0;
	endtask

	task pin(input logic [4:0] e, input logic [4:0] m);
		@(posedge i_mclk);
		probe <= 1'b1;
		note_q.push_back({11'h000, e, 11'h000, m});
		@(posedge i_mclk);
		probe <= 1'b0;
	endtask

	task wait_bit(input int i, input logic v);
		int k;
		k = 0;
		while (pins[i] !== v && k < 1000) begin
			@(posedge i_mclk);
			k++;
		end
		if (k == 1000) begin
			n_fail++;
			test_done();
		end
	endtask

	task zc;
		@(posedge i_mclk);
		sync_low <= 1'b1;
		step(4);
		sync_low <= 1'b0;
	endtask

	task supply(input logic [1:0] p);
		@(posedge i_mclk);
		vs_low <= 1'b1;
		vs_en <= 1'b0;
		i_prog <= p;
		step(6);
		pin(5'h00, 5'h0f);
		rd(rps_pkg::ADDR_STATE, 16'h0000, 16'h0100);
		vs_low <= 1'b0;
		step(6);
		rd(rps_pkg::ADDR_STATE, 16'h0000, 16'h0100);
		vs_en <= 1'b1;
		step(6);
		rd(rps_pkg::ADDR_STATE, {8'h01, p, 6'h00}, 16'h01c0);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(79));
		ctl_lvl = 10'h064 + 10'($urandom % 200);
		step(16);
		i_srst <= 1'b0;
		rd(rps_pkg::ADDR_CTRL, 16'h0000, 16'hffff);
		rd(rps_pkg::ADDR_STATUS, 16'h0000, 16'hffff);
		rd(rps_pkg::ADDR_MASK, 16'h0000, 16'hffff);
		rd(4'h2, 16'h0000, 16'hffff);
		supply(2'h0);
		rd(rps_pkg::ADDR_STATE, 16'h0801, 16'h0801);
		zc();
		step(1);
		pin(5'h06, 5'h0f);
		wait_bit(3, 1'b1);
		pin(5'h0a, 5'h0f);
		wait_bit(3, 1'b0);
		pin(5'h06, 5'h0f);
		wait_bit(0, 1'b1);
		pin(5'h01, 5'h0f);
		wait_bit(0, 1'b0);
		step(20 + ($urandom % 30));
		pin(5'h00, 5'h0f);
		rd(rps_pkg::ADDR_STATUS, 16'h0007, 16'h0007);
		rd(rps_pkg::ADDR_STATE, 16'h0000, 16'h0800);
		wr(rps_pkg::ADDR_STATUS, 16'h003f);
		rd(rps_pkg::ADDR_STATUS, 16'h0000, 16'h003f);
		// interrupt raised, masked and cleared
		wr(rps_pkg::ADDR_MASK, 16'h0001);
		zc();
		step(2);
		pin(5'h10, 5'h10);
		wr(rps_pkg::ADDR_MASK, 16'h0000);
		step(2);
		pin(5'h00, 5'h10);
		wr(rps_pkg::ADDR_MASK, 16'h0001);
		step(2);
		pin(5'h10, 5'h10);
		wr(rps_pkg::ADDR_STATUS, 16'h0001);
		step(2);
		pin(5'h00, 5'h10);
		wait_bit(0, 1'b1);
		pin(5'h01, 5'h09);
		// brownout in reverse mode
		wr(rps_pkg::ADDR_CTRL, 16'h0001);
		wait_bit(0, 1'b0);
		zc();
		wait_bit(3, 1'b1);
		vs_brown <= 1'b1;
		vs_en <= 1'b0;
		step(6);
		pin(5'h00, 5'h08);
		rd(rps_pkg::ADDR_STATE, 16'h0500, 16'h0500);
		rd(rps_pkg::ADDR_STATUS, 16'h0008, 16'h0028);
		vs_brown <= 1'b0;
		vs_en <= 1'b1;
		step(30);
		pin(5'h00, 5'h08);
		wait_bit(0, 1'b0);
		zc();
		wait_bit(3, 1'b1);
		// over-temperature latch
		otemp <= 1'b1;
		step(6);
		pin(5'h00, 5'h08);
		rd(rps_pkg::ADDR_STATE, 16'h0200, 16'h0200);
		otemp <= 1'b0;
		wait_bit(0, 1'b0);
		zc();
		step(40);
		pin(5'h00, 5'h08);
		supply(2'h1);
		rd(rps_pkg::ADDR_STATE, 16'h0000, 16'h0200);
		rd(rps_pkg::ADDR_STATUS, 16'h0030, 16'h0030);
		// static mode counts every second crossing
		wr(rps_pkg::ADDR_CTRL, 16'h0003);
		zc();
		step(20);
		pin(5'h00, 5'h08);
		zc();
		wait_bit(3, 1'b1);
		supply(2'h2);
		// switch-off variant: one power-up cycle, then held off
		wr(rps_pkg::ADDR_CTRL, 16'h0000);
		zc();
		wait_bit(3, 1'b1);
		wait_bit(0, 1'b1);
		wait_bit(0, 1'b0);
		zc();
		step(30);
		pin(5'h02, 5'h0f);
		test_done();
	end
endmodule
